// ---- rtl/rtccal_pkg.sv ----
// Package: register map, field layout and timing constants of the calendar block
package rtccal_pkg;
  localparam logic [7:0] OFS_CAL_SEC     = 8'h40;
  localparam logic [7:0] OFS_CAL_MIN     = 8'h41;
  localparam logic [7:0] OFS_CAL_HOUR    = 8'h42;
  localparam logic [7:0] OFS_CAL_DAY     = 8'h43;
  localparam logic [7:0] OFS_CAL_MONTH   = 8'h44;
  localparam logic [7:0] OFS_CAL_YEAR    = 8'h45;
  localparam logic [7:0] OFS_WAKE_SEC    = 8'h46;
  localparam logic [7:0] OFS_WAKE_MIN    = 8'h47;
  localparam logic [7:0] OFS_WAKE_HOUR   = 8'h48;
  localparam logic [7:0] OFS_WAKE_DAY    = 8'h49;
  localparam logic [7:0] OFS_WAKE_MONTH  = 8'h4a;
  localparam logic [7:0] OFS_WAKE_YEAR   = 8'h4b;
  localparam logic [7:0] OFS_ELAPSED_B0  = 8'h4c;
  localparam logic [7:0] OFS_ELAPSED_B1  = 8'h4d;
  localparam logic [7:0] OFS_ELAPSED_B2  = 8'h4e;
  localparam logic [7:0] OFS_ELAPSED_B3  = 8'h4f;
  // Shadow page holding the frozen calendar copy
  localparam logic [8:0] OFS_SHADOW_LO   = 9'h104;
  localparam logic [8:0] OFS_SHADOW_HI   = 9'h109;

  localparam int BIT_CAL_READY    = 7;
  localparam int BIT_GUARD        = 6;
  localparam int BIT_TICK_WAKE    = 5;
  localparam int BIT_TICK_MINUTE  = 4;
  localparam int BIT_TICK_ON      = 7;
  localparam int BIT_ALARM_ON     = 6;

  localparam logic [1:0] REASON_NONE  = 2'h0;
  localparam logic [1:0] REASON_TICK  = 2'h1;
  localparam logic [1:0] REASON_TIMER = 2'h2;

  localparam logic [5:0] RST_SEC   = 6'h00;
  localparam logic [4:0] RST_HOUR  = 5'h00;
  localparam logic [4:0] RST_DAY   = 5'h01;
  localparam logic [3:0] RST_MONTH = 4'h1;
  localparam logic [5:0] RST_YEAR  = 6'h00;
  localparam logic [5:0] LAST_MINSEC = 6'h3b;
  localparam logic [4:0] LAST_HOUR   = 5'h17;
  localparam logic [3:0] LAST_MONTH  = 4'hc;

  // Edges after release before the backup guard synchroniser holds real data
  localparam logic [1:0] GUARD_SETTLE = 2'h2;

  localparam int CLOCK_HZ       = 50_000_000;
  localparam int SECOND_MS      = 1000;
  localparam int SECOND_CYCLES  = CLOCK_HZ / 1000 * SECOND_MS;

  typedef struct packed {
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [4:0] day;
    logic [3:0] month;
    logic [5:0] year;
  } rtccal_time_type;
endpackage

// ---- rtl/rtccal_second_div.sv ----
// Divider producing a one-cycle pulse once per second while running
`timescale 1ns/1ps
module rtccal_second_div #(
  parameter int CYCLES = rtccal_pkg::SECOND_CYCLES
) (
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  input  wire logic run_in,
  input  wire logic restart_in,
  output logic      pulse_out
);
  typedef struct packed {
    logic [31:0] count;
    logic        pulse;
  } rtccal_div_type;

  rtccal_div_type state_q;
  rtccal_div_type state_d;

  always_comb
  begin
    state_d       = state_q;
    state_d.pulse = 1'b0;
    if (restart_in || !run_in)
    begin
      state_d.count = 32'h0000_0000;
    end
    else if (state_q.count == 32'(CYCLES - 1))
    begin
      state_d.count = 32'h0000_0000;
      state_d.pulse = 1'b1;
    end
    else
    begin
      state_d.count = state_q.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign pulse_out = state_q.pulse;
endmodule

// ---- rtl/rtccal_time_step.sv ----
// Combinational one-second advance of the calendar, with month lengths and leap years
`timescale 1ns/1ps
module rtccal_time_step (
  input  rtccal_pkg::rtccal_time_type now_in,
  output rtccal_pkg::rtccal_time_type next_out,
  output logic                        minute_wrap_out
);
  function automatic logic [4:0] month_days(input logic [3:0] month, input logic [5:0] year);
    logic [4:0] days;
    days = 5'h1f;
    case (month)
      4'h4, 4'h6, 4'h9, 4'hb: days = 5'h1e;
      4'h2: days = (year[1:0] == 2'h0) ? 5'h1d : 5'h1c;
      default: days = 5'h1f;
    endcase
    return days;
  endfunction

  always_comb
  begin
    next_out        = now_in;
    minute_wrap_out = 1'b0;
    if (now_in.sec >= rtccal_pkg::LAST_MINSEC)
    begin
      next_out.sec    = rtccal_pkg::RST_SEC;
      minute_wrap_out = 1'b1;
      if (now_in.min >= rtccal_pkg::LAST_MINSEC)
      begin
        next_out.min = rtccal_pkg::RST_SEC;
        if (now_in.hour >= rtccal_pkg::LAST_HOUR)
        begin
          next_out.hour = rtccal_pkg::RST_HOUR;
          if (now_in.day >= month_days(now_in.month, now_in.year))
          begin
            next_out.day = rtccal_pkg::RST_DAY;
            if (now_in.month >= rtccal_pkg::LAST_MONTH)
            begin
              next_out.month = rtccal_pkg::RST_MONTH;
              next_out.year  = now_in.year + 6'h01;
            end
            else
            begin
              next_out.month = now_in.month + 4'h1;
            end
          end
          else
          begin
            next_out.day = now_in.day + 5'h01;
          end
        end
        else
        begin
          next_out.hour = now_in.hour + 5'h01;
        end
      end
      else
      begin
        next_out.min = now_in.min + 6'h01;
      end
    end
    else
    begin
      next_out.sec = now_in.sec + 6'h01;
    end
  end
endmodule

// ---- rtl/rtccal_regs.sv ----
// Calendar, alarm, tick and elapsed-seconds registers behind a plain register port
//
// How it works
// - Seconds register bit 7 reads high when the calendar may be read.
// - Calendar seconds..month writes are staged, applied when year is written.
// - Reading calendar seconds copies the running calendar into the shadow page.
// - Minutes..year reads return the copy frozen by the last seconds read.
// - Calendar year is six bits, offset from 2000, covering 2000 to 2063.
// - Writing calendar year starts the clock and loads staged calendar values.
// - Guard bit reads 0 after power loss, 1 when the clock is healthy.
// - Guard bit 1 locks oscillator settings; once set, year writes are ignored.
// - At core power-on the guard bit is taken from the backup domain.
// - Alarm seconds bits 7:6 report wake reason: none, tick, timer, both.
// - Alarm seconds..month fields are staged, applied when alarm year is written; the tick-wake and tick-period bits apply at once.
// - Alarm fields: sec/min six bits, hours five, days five, months four.
// - Tick-wake bit lets a tick wake the chip from clock-only mode.
// - Tick-period bit selects a tick each second (0) or each minute (1).
// - Alarm year bit 7 enables ticks; none are made while it is clear.
// - Alarm year bit 6 enables the alarm, firing on calendar match.
// - Alarm year is six bits, offset from 2000, covering 2000 to 2063.
// - A 32-bit running seconds counter reads as four bytes, low byte first.
// - Reading the low byte freezes the three upper bytes for later reads.
`timescale 1ns/1ps
module rtccal_regs #(
  parameter int SECOND_CYCLES = rtccal_pkg::SECOND_CYCLES
) (
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  input  wire logic [8:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic       backup_guard_in,
  input  wire logic       backup_supply_ok_in,
  output logic [7:0]      rdata_out,
  output logic            osc_cfg_lock_out,
  output logic            clock_running_out,
  output logic            wake_event_out,
  output logic            tick_wake_out
);
  typedef struct packed {
    rtccal_pkg::rtccal_time_type cal;
    rtccal_pkg::rtccal_time_type cal_stage;
    rtccal_pkg::rtccal_time_type shadow;
    rtccal_pkg::rtccal_time_type wake;
    rtccal_pkg::rtccal_time_type wake_stage;
    logic        guard;
    logic        guard_loaded;
    logic [1:0]  settle;
    logic        running;
    logic        tick_wake;
    logic        tick_minute;
    logic        tick_on;
    logic        alarm_on;
    logic [1:0]  reason;
    logic [31:0] elapsed;
    logic [23:0] elapsed_frozen;
    logic [7:0]  rdata;
    logic        event_p;
    logic        ok_s1;
    logic        ok_s2;
    logic        gd_s1;
    logic        gd_s2;
  } rtccal_state_type;

  rtccal_state_type            state_q;
  rtccal_state_type            state_d;
  rtccal_pkg::rtccal_time_type cal_next;
  logic                        minute_wrap;
  logic                        second_pulse;

  rtccal_second_div #(
    .CYCLES (SECOND_CYCLES)
  ) u_div (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .run_in     (state_q.running),
    .restart_in (wr_in && addr_in == {1'b0, rtccal_pkg::OFS_CAL_YEAR} && !state_q.guard),
    .pulse_out  (second_pulse)
  );

  rtccal_time_step u_step (
    .now_in          (state_q.cal),
    .next_out        (cal_next),
    .minute_wrap_out (minute_wrap)
  );

  function automatic logic alarm_match(input rtccal_pkg::rtccal_time_type a,
                                       input rtccal_pkg::rtccal_time_type b);
    return a == b;
  endfunction

  always_comb
  begin
    logic        tick;
    logic        timer;
    logic [8:0]  shadow_idx;
    state_d         = state_q;
    state_d.event_p = 1'b0;
    state_d.rdata   = 8'h00;
    tick            = 1'b0;
    timer           = 1'b0;
    shadow_idx      = addr_in - rtccal_pkg::OFS_SHADOW_LO;
    // Supply-ok and backup guard come from another domain
    state_d.ok_s1 = backup_supply_ok_in;
    state_d.ok_s2 = state_q.ok_s1;
    state_d.gd_s1 = backup_guard_in;
    state_d.gd_s2 = state_q.gd_s1;
    // Synchroniser still holds reset zeros just after release, so wait it out
    if (!state_q.guard_loaded)
    begin
      if (state_q.settle == rtccal_pkg::GUARD_SETTLE)
      begin
        state_d.guard        = state_q.gd_s2;
        state_d.guard_loaded = 1'b1;
      end
      else
      begin
        state_d.settle = state_q.settle + 2'h1;
      end
    end
    if (state_q.guard && !state_q.ok_s2)
    begin
      state_d.guard = 1'b0;
    end

    // Timekeeping
    if (second_pulse && state_q.running)
    begin
      state_d.cal     = cal_next;
      state_d.elapsed = state_q.elapsed + 32'h0000_0001;
      tick  = state_q.tick_on && (!state_q.tick_minute || minute_wrap);
      timer = state_q.alarm_on && alarm_match(cal_next, state_q.wake);
    end
    if (tick || timer)
    begin
      // Reason accumulates until the host rewrites the alarm year
      state_d.reason  = state_q.reason | {timer, tick};
      state_d.event_p = 1'b1;
    end

    // Register writes
    if (wr_in && !addr_in[8])
    begin
      case (addr_in[7:0])
        rtccal_pkg::OFS_CAL_SEC:   state_d.cal_stage.sec   = wdata_in[5:0];
        rtccal_pkg::OFS_CAL_MIN:   state_d.cal_stage.min   = wdata_in[5:0];
        rtccal_pkg::OFS_CAL_HOUR:  state_d.cal_stage.hour  = wdata_in[4:0];
        rtccal_pkg::OFS_CAL_DAY:   state_d.cal_stage.day   = wdata_in[4:0];
        rtccal_pkg::OFS_CAL_MONTH: state_d.cal_stage.month = wdata_in[3:0];
        rtccal_pkg::OFS_CAL_YEAR:
        begin
          if (!state_q.guard)
          begin
            state_d.cal         = state_q.cal_stage;
            state_d.cal.year    = wdata_in[5:0];
            state_d.cal_stage.year = wdata_in[5:0];
            state_d.running     = 1'b1;
            state_d.guard       = wdata_in[rtccal_pkg::BIT_GUARD];
          end
        end
        rtccal_pkg::OFS_WAKE_SEC:  state_d.wake_stage.sec  = wdata_in[5:0];
        rtccal_pkg::OFS_WAKE_MIN:  state_d.wake_stage.min  = wdata_in[5:0];
        rtccal_pkg::OFS_WAKE_HOUR: state_d.wake_stage.hour = wdata_in[4:0];
        rtccal_pkg::OFS_WAKE_DAY:  state_d.wake_stage.day  = wdata_in[4:0];
        rtccal_pkg::OFS_WAKE_MONTH:
        begin
          state_d.wake_stage.month = wdata_in[3:0];
          state_d.tick_wake   = wdata_in[rtccal_pkg::BIT_TICK_WAKE];
          state_d.tick_minute = wdata_in[rtccal_pkg::BIT_TICK_MINUTE];
        end
        rtccal_pkg::OFS_WAKE_YEAR:
        begin
          state_d.wake      = state_q.wake_stage;
          state_d.wake.year = wdata_in[5:0];
          state_d.wake_stage.year = wdata_in[5:0];
          state_d.tick_on   = wdata_in[rtccal_pkg::BIT_TICK_ON];
          state_d.alarm_on  = wdata_in[rtccal_pkg::BIT_ALARM_ON];
          // Event in the same cycle still wins over the clear
          state_d.reason    = {timer, tick};
        end
        default: ;
      endcase
    end

    // Register reads, data valid the cycle after the strobe
    if (rd_in)
    begin
      if (addr_in >= rtccal_pkg::OFS_SHADOW_LO && addr_in <= rtccal_pkg::OFS_SHADOW_HI)
      begin
        case (shadow_idx[2:0])
          3'h0: state_d.rdata = {2'h0, state_q.shadow.sec};
          3'h1: state_d.rdata = {2'h0, state_q.shadow.min};
          3'h2: state_d.rdata = {3'h0, state_q.shadow.hour};
          3'h3: state_d.rdata = {3'h0, state_q.shadow.day};
          3'h4: state_d.rdata = {4'h0, state_q.shadow.month};
          default: state_d.rdata = {1'b0, state_q.guard, state_q.shadow.year};
        endcase
      end
      else if (!addr_in[8])
      begin
        case (addr_in[7:0])
          rtccal_pkg::OFS_CAL_SEC:
          begin
            state_d.shadow = state_q.cal;
            state_d.rdata  = {state_q.running, 1'b0, state_q.cal.sec};
          end
          rtccal_pkg::OFS_CAL_MIN:   state_d.rdata = {2'h0, state_q.shadow.min};
          rtccal_pkg::OFS_CAL_HOUR:  state_d.rdata = {3'h0, state_q.shadow.hour};
          rtccal_pkg::OFS_CAL_DAY:   state_d.rdata = {3'h0, state_q.shadow.day};
          rtccal_pkg::OFS_CAL_MONTH: state_d.rdata = {4'h0, state_q.shadow.month};
          rtccal_pkg::OFS_CAL_YEAR:
            state_d.rdata = {1'b0, state_q.guard, state_q.shadow.year};
          rtccal_pkg::OFS_WAKE_SEC:  state_d.rdata = {state_q.reason, state_q.wake.sec};
          rtccal_pkg::OFS_WAKE_MIN:  state_d.rdata = {2'h0, state_q.wake.min};
          rtccal_pkg::OFS_WAKE_HOUR: state_d.rdata = {3'h0, state_q.wake.hour};
          rtccal_pkg::OFS_WAKE_DAY:  state_d.rdata = {3'h0, state_q.wake.day};
          rtccal_pkg::OFS_WAKE_MONTH:
            state_d.rdata = {2'h0, state_q.tick_wake, state_q.tick_minute, state_q.wake.month};
          rtccal_pkg::OFS_WAKE_YEAR:
            state_d.rdata = {state_q.tick_on, state_q.alarm_on, state_q.wake.year};
          rtccal_pkg::OFS_ELAPSED_B0:
          begin
            state_d.elapsed_frozen = state_q.elapsed[31:8];
            state_d.rdata          = state_q.elapsed[7:0];
          end
          rtccal_pkg::OFS_ELAPSED_B1: state_d.rdata = state_q.elapsed_frozen[7:0];
          rtccal_pkg::OFS_ELAPSED_B2: state_d.rdata = state_q.elapsed_frozen[15:8];
          rtccal_pkg::OFS_ELAPSED_B3: state_d.rdata = state_q.elapsed_frozen[23:16];
          default: state_d.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q                <= '0;
      state_q.cal.day        <= rtccal_pkg::RST_DAY;
      state_q.cal.month      <= rtccal_pkg::RST_MONTH;
      state_q.cal_stage.day  <= rtccal_pkg::RST_DAY;
      state_q.cal_stage.month <= rtccal_pkg::RST_MONTH;
      state_q.shadow.day     <= rtccal_pkg::RST_DAY;
      state_q.shadow.month   <= rtccal_pkg::RST_MONTH;
      state_q.wake.day       <= rtccal_pkg::RST_DAY;
      state_q.wake.month     <= rtccal_pkg::RST_MONTH;
      state_q.wake_stage.day <= rtccal_pkg::RST_DAY;
      state_q.wake_stage.month <= rtccal_pkg::RST_MONTH;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign rdata_out         = state_q.rdata;
  assign osc_cfg_lock_out  = state_q.guard;
  assign clock_running_out = state_q.running;
  assign wake_event_out    = state_q.event_p;
  assign tick_wake_out     = state_q.tick_wake;
endmodule

// ---- testbench/rtccal_monitor.sv ----
// Port-level assertions for the calendar register block
`timescale 1ns/1ps
module rtccal_monitor #(
  parameter int SECOND_CYCLES = 10
) (
  input wire logic       clock_in,
  input wire logic       reset_n_in,
  input wire logic [8:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic       backup_guard_in,
  input wire logic       backup_supply_ok_in,
  input wire logic [7:0] rdata_out,
  input wire logic       osc_cfg_lock_out,
  input wire logic       clock_running_out,
  input wire logic       wake_event_out,
  input wire logic       tick_wake_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);
  wire logic yr_wr = wr_in && (addr_in == 9'h045);
  wire logic ok    = backup_supply_ok_in;
  property p_run_start;
    yr_wr && !osc_cfg_lock_out |=> clock_running_out;
  endproperty
  a_run_start: assert property (p_run_start) else $error("year write did not start clock");
  property p_run_hold;
    clock_running_out |=> clock_running_out;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("clock stopped on its own");
  property p_lock_set;
    yr_wr && wdata_in[6] && !osc_cfg_lock_out && ok |=> osc_cfg_lock_out;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("guard write did not lock");
  // Supply must be steady through the two-stage sync for the lock to hold
  property p_lock_keep;
    yr_wr && osc_cfg_lock_out && ok && $past(ok) && $past(ok, 2) |=> osc_cfg_lock_out;
  endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("locked guard was cleared");
  property p_lock_lost;
    (!ok) [*4] |-> !osc_cfg_lock_out;
  endproperty
  a_lock_lost: assert property (p_lock_lost) else $error("guard kept after power loss");
  property p_ready;
    rd_in && addr_in == 9'h040 |=> rdata_out[7:6] == {$past(clock_running_out), 1'b0};
  endproperty
  a_ready: assert property (p_ready) else $error("ready bit wrong");
  property p_rsvd;
    rd_in && (addr_in == 9'h042 || addr_in == 9'h043) |=> rdata_out[7:5] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_event;
    wake_event_out |=> !wake_event_out;
  endproperty
  a_event: assert property (p_event) else $error("wake event longer than a cycle");
endmodule
bind rtccal_regs rtccal_monitor #(.SECOND_CYCLES(SECOND_CYCLES)) i_mon (
  .clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .backup_guard_in(backup_guard_in),
  .backup_supply_ok_in(backup_supply_ok_in), .rdata_out(rdata_out),
  .osc_cfg_lock_out(osc_cfg_lock_out), .clock_running_out(clock_running_out),
  .wake_event_out(wake_event_out), .tick_wake_out(tick_wake_out)
);

// ---- testbench/rtccal_host_model.sv ----
// Host processor model issuing register reads and writes
`timescale 1ns/1ps
module rtccal_host_model (
  input  wire logic       clock_in,
  input  wire logic [7:0] rdata_in,
  output logic [8:0]      addr_out,
  output logic [7:0]      wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  initial
  begin
    addr_out = 9'h000;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  task automatic write(input logic [8:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clock_in);
    wr_out    <= 1'b0;
    // Released data bus must not keep looking valid
    wdata_out <= ~d;
  endtask
  task automatic read(input logic [8:0] a, output logic [7:0] d);
    @(posedge clock_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clock_in);
    rd_out   <= 1'b0;
    // Data stands only up to this edge; taken before it is replaced
    @(posedge clock_in);
    d = rdata_in;
  endtask
endmodule

// ---- testbench/rtccal_regs_tb.sv ----
// Self-checking bench for the calendar and alarm register block
`timescale 1ns/1ps
module rtccal_regs_tb;
  localparam int SEC = 10;
  localparam logic [7:0] FROZ [0:5] = '{8'hba, 8'h3b, 8'h17, 8'h1e, 8'h0b, 8'h3f};
  localparam logic [7:0] ROLL [0:5] = '{8'h80, 8'h00, 8'h00, 8'h01, 8'h0c, 8'h3f};
  logic       clock_in   = 1'b0;
  logic       reset_n_in = 1'b0;
  logic       guard_src  = 1'b1;
  logic       supply_ok  = 1'b1;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       lock;
  logic       running;
  logic       wake_ev;
  logic       tick_wake;
  int         error_cnt   = 0;
  int         checks_done = 0;
  int         cyc         = 0;
  int         w0          = 0;
  int         n;
  always #10 clock_in = ~clock_in;
  rtccal_regs #(.SECOND_CYCLES(SEC)) i_dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .backup_guard_in(guard_src), .backup_supply_ok_in(supply_ok),
    .rdata_out(rdata), .osc_cfg_lock_out(lock), .clock_running_out(running),
    .wake_event_out(wake_ev), .tick_wake_out(tick_wake)
  );
  rtccal_host_model i_host (
    .clock_in(clock_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd)
  );
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 4500)
    begin
      error_cnt = error_cnt + 1;
      final_report();
    end
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rchk(input logic [8:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_host.read(a, v);
    check($sformatf("reg %h", a), v, e);
  endtask
  task automatic rsn(input logic [1:0] e);
    logic [7:0] v;
    i_host.read(9'h046, v);
    check("wake reason", {6'h00, v[7:6]}, {6'h00, e});
  endtask
  task automatic do_reset(input logic g);
    @(posedge clock_in);
    guard_src  <= g;
    reset_n_in <= 1'b0;
    repeat (12) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    #1;
  endtask
  task automatic wait_to(input int t);
    while (cyc < w0 + t) @(posedge clock_in);
  endtask
  task automatic count_ev(input int len, output int c);
    c = 0;
    repeat (len)
    begin
      @(posedge clock_in);
      #1 if (wake_ev === 1'b1) c++;
    end
  endtask
  task automatic t_guard_kept;
    check("lock", {7'h00, lock}, 8'h01);
    i_host.write(9'h045, 8'h05);
    @(posedge clock_in);
    #1 check("running", {7'h00, running}, 8'h00);
    rchk(9'h040, 8'h00);
    rchk(9'h045, 8'h40);
    @(posedge clock_in);
    supply_ok <= 1'b0;
    repeat (5) @(posedge clock_in);
    supply_ok <= 1'b1;
    rchk(9'h040, 8'h00);
    rchk(9'h045, 8'h00);
  endtask
  task automatic t_commit;
    for (int i = 0; i < 5; i++) i_host.write(9'(i) + 9'h040, FROZ[i] & 8'h3f);
    rchk(9'h040, 8'h00);
    rchk(9'h041, 8'h00);
    i_host.write(9'h045, 8'h3f);
    w0 = cyc;
    for (int i = 0; i < 6; i++) rchk(9'(i) + 9'h040, FROZ[i]);
    rchk(9'h105, 8'h3b);
    rchk(9'h109, 8'h3f);
    wait_to(25);
    rchk(9'h041, 8'h3b);
    for (int i = 0; i < 6; i++) rchk(9'(i) + 9'h040, ROLL[i]);
  endtask
  task automatic t_tick;
    i_host.write(9'h04a, 8'h2c);
    i_host.write(9'h04b, 8'hbf);
    wait_to(55);
    count_ev(30, n);
    check("ticks per second", n[7:0], 8'h03);
    check("tick wake", {7'h00, tick_wake}, 8'h01);
    rsn(2'h1);
    i_host.write(9'h04a, 8'h3c);
    i_host.write(9'h04b, 8'hbf);
    wait_to(105);
    count_ev(600, n);
    check("ticks per minute", n[7:0], 8'h01);
    i_host.write(9'h04b, 8'h3f);
    wait_to(715);
    count_ev(30, n);
    check("ticks off", n[7:0], 8'h00);
    rsn(2'h0);
  endtask
  task automatic t_elapsed;
    wait_to(2555);
    rchk(9'h04c, 8'hff);
    wait_to(2575);
    rchk(9'h04d, 8'h00);
    wait_to(2585);
    rchk(9'h04c, 8'h02);
    rchk(9'h04d, 8'h01);
    rchk(9'h04e, 8'h00);
    rchk(9'h04f, 8'h00);
  endtask
  task automatic t_alarm;
    i_host.write(9'h046, 8'h00);
    i_host.write(9'h047, 8'h05);
    i_host.write(9'h048, 8'h00);
    i_host.write(9'h049, 8'h01);
    i_host.write(9'h04a, 8'h0c);
    i_host.write(9'h04b, 8'hff);
    // Staged only, so the committed alarm time stays put
    i_host.write(9'h046, 8'h10);
    wait_to(3010);
    rsn(2'h1);
    wait_to(3030);
    rsn(2'h3);
    i_host.write(9'h046, 8'h03);
    i_host.write(9'h04b, 8'h7f);
    wait_to(3042);
    count_ev(20, n);
    check("alarm events", n[7:0], 8'h01);
    rsn(2'h2);
  endtask
  task automatic t_lock_set;
    logic [7:0] v;
    i_host.write(9'h045, 8'h7f);
    @(posedge clock_in);
    #1 check("lock set", {7'h00, lock}, 8'h01);
    i_host.write(9'h045, 8'h05);
    i_host.read(9'h040, v);
    rchk(9'h045, 8'h7f);
  endtask
  initial
  begin
    do_reset(1'b1);
    t_guard_kept();
    do_reset(1'b0);
    t_commit();
    t_tick();
    t_elapsed();
    t_alarm();
    t_lock_set();
    final_report();
  end
endmodule
